/* cgl_pkg.sv */
// package: register map, field layout and enumerations for the camera gpio line control
package cgl_pkg;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [11:0] OFF_CHOICE    = 12'h000;
    localparam logic [11:0] OFF_DIRECTION = 12'h004;
    localparam logic [11:0] OFF_FLIP      = 12'h008;
    localparam logic [11:0] OFF_READBACK  = 12'h00C;
    localparam logic [11:0] OFF_PACKED    = 12'h010;
    localparam logic [11:0] OFF_DRIVE_SEL = 12'h014;
    localparam logic [11:0] OFF_AUX_RAIL  = 12'h018;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [1:0] RST_CHOICE = 2'h0;
    localparam logic [3:0] RST_DIR    = 4'h0;
    localparam logic [3:0] RST_FLIP   = 4'h0;
    localparam logic       RST_AUX    = 1'b0;

    localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;

    // ************************************************************
    // drive source encodings
    // ************************************************************
    typedef enum logic [2:0] {
        SRC_OFF,
        SRC_LINE0,
        SRC_LINE1,
        SRC_LINE2,
        SRC_LINE3,
        SRC_EXPOSING,
        SRC_TRIG_READY,
        SRC_SERIAL_TX
    } cgl_src_t;

    // ************************************************************
    // apb request carrier
    // ************************************************************
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cgl_apb_req_t;

endpackage

/* cgl_gpio_ctrl.sv */
// camera gpio line control: apb registers, per-line direction, polarity and drive source
// ************************************************************
// ************************************************************
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps
module cgl_gpio_ctrl #(
    parameter int LINES = 4
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // acquisition and serial sources
    input  wire logic              sensor_exposing_flag,
    input  wire logic              trigger_ready_flag,
    input  wire logic              serial_tx_data,
    output logic                   serial_rx_data,
    // pins
    input  wire logic [LINES-1:0]  io_pin_in,
    output logic      [LINES-1:0]  io_pin_out,
    output logic      [LINES-1:0]  io_pin_oe,
    output logic                   aux_rail_on
);

    // ************************************************************
    // state
    // ************************************************************
    cgl_pkg::cgl_apb_req_t req;
    logic [1:0]       io_pin_choice_reg;
    logic [LINES-1:0] pin_direction_reg;
    logic [LINES-1:0] pin_polarity_flip_reg;
    cgl_pkg::cgl_src_t pin_drive_select_reg [LINES];
    logic [LINES-1:0] sync1_reg;
    logic [LINES-1:0] sync2_reg;
    logic [LINES-1:0] level;
    logic [LINES-1:0] drive_next;
    logic             wr_en;
    logic             rd_en;
    logic [31:0]      prdata_next;
    logic             slverr_next;

    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    // writes land at the access edge, where the master samples pready
    assign wr_en = req.sel && req.enable && req.write && pready;
    assign rd_en = req.sel && !req.enable && !req.write;

    // ************************************************************
    // input synchroniser and logical level
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= io_pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    // driven lines read back their own drive, inputs the pin through the flip
    assign level = (io_pin_oe & io_pin_out)
                 | (~io_pin_oe & (sync2_reg ^ pin_polarity_flip_reg));

    // ************************************************************
    // register writes
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_pin_choice_reg     <= cgl_pkg::RST_CHOICE;
            pin_direction_reg     <= cgl_pkg::RST_DIR;
            pin_polarity_flip_reg <= cgl_pkg::RST_FLIP;
            aux_rail_on           <= cgl_pkg::RST_AUX;
            for (int i = 0; i < LINES; i++) begin
                pin_drive_select_reg[i] <= cgl_pkg::SRC_OFF;
            end
        end else if (wr_en) begin
            if (req.addr == cgl_pkg::OFF_CHOICE) begin
                io_pin_choice_reg <= req.wdata[1:0];
            end else if (req.addr == cgl_pkg::OFF_DIRECTION) begin
                pin_direction_reg[io_pin_choice_reg] <= req.wdata[0];
            end else if (req.addr == cgl_pkg::OFF_FLIP) begin
                pin_polarity_flip_reg[io_pin_choice_reg] <= req.wdata[0];
            end else if (req.addr == cgl_pkg::OFF_DRIVE_SEL) begin
                pin_drive_select_reg[io_pin_choice_reg] <= cgl_pkg::cgl_src_t'(req.wdata[2:0]);
            end else if (req.addr == cgl_pkg::OFF_AUX_RAIL) begin
                aux_rail_on <= req.wdata[0];
            end
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    always_comb begin
        prdata_next = cgl_pkg::BAD_ADDR_DATA;
        slverr_next = 1'b0;
        if (req.addr == cgl_pkg::OFF_CHOICE) begin
            prdata_next = {30'h0000_0000, io_pin_choice_reg};
        end else if (req.addr == cgl_pkg::OFF_DIRECTION) begin
            prdata_next = {31'h0000_0000, pin_direction_reg[io_pin_choice_reg]};
        end else if (req.addr == cgl_pkg::OFF_FLIP) begin
            prdata_next = {31'h0000_0000, pin_polarity_flip_reg[io_pin_choice_reg]};
        end else if (req.addr == cgl_pkg::OFF_READBACK) begin
            prdata_next = {31'h0000_0000, level[io_pin_choice_reg]};
        end else if (req.addr == cgl_pkg::OFF_PACKED) begin
            prdata_next = {28'h000_0000, level};
        end else if (req.addr == cgl_pkg::OFF_DRIVE_SEL) begin
            prdata_next = {29'h0000_0000, pin_drive_select_reg[io_pin_choice_reg]};
        end else if (req.addr == cgl_pkg::OFF_AUX_RAIL) begin
            prdata_next = {31'h0000_0000, aux_rail_on};
        end else begin
            slverr_next = 1'b1;
        end
    end

    // answer in the access phase: pready high one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= req.sel && !req.enable;
            pslverr <= req.sel && !req.enable && slverr_next;
            if (rd_en) begin
                prdata <= prdata_next;
            end
        end
    end

    // ************************************************************
    // drive source selection
    // ************************************************************
    always_comb begin
        for (int i = 0; i < LINES; i++) begin
            case (pin_drive_select_reg[i])
                cgl_pkg::SRC_LINE0:      drive_next[i] = sync2_reg[0];
                cgl_pkg::SRC_LINE1:      drive_next[i] = sync2_reg[1];
                cgl_pkg::SRC_LINE2:      drive_next[i] = sync2_reg[2];
                cgl_pkg::SRC_LINE3:      drive_next[i] = sync2_reg[3];
                cgl_pkg::SRC_EXPOSING:   drive_next[i] = sensor_exposing_flag;
                cgl_pkg::SRC_TRIG_READY: drive_next[i] = trigger_ready_flag;
                cgl_pkg::SRC_SERIAL_TX:  drive_next[i] = (i == 0) ? serial_tx_data : 1'b0;
                default:                 drive_next[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_pin_out     <= '0;
            io_pin_oe      <= '0;
            serial_rx_data <= 1'b1;
        end else begin
            io_pin_oe      <= pin_direction_reg;
            io_pin_out     <= (drive_next & pin_direction_reg) ^ pin_polarity_flip_reg;
            serial_rx_data <= sync2_reg[1] ^ pin_polarity_flip_reg[1];
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_rail_reset;
        @(posedge pclk) $rose(presetn) |-> !aux_rail_on && io_pin_oe == '0;
    endproperty
    a_rail_reset: assert property (p_rail_reset) else $error("outputs not idle after reset");

    property p_oe_follows_dir;
        @(posedge pclk) disable iff (!presetn) io_pin_oe == $past(pin_direction_reg);
    endproperty
    a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("enable not direction");

    property p_expose_drive;
        @(posedge pclk) disable iff (!presetn)
            pin_direction_reg[2] && !pin_polarity_flip_reg[2]
            && pin_drive_select_reg[2] == cgl_pkg::SRC_EXPOSING && sensor_exposing_flag
            |=> io_pin_out[2];
    endproperty
    a_expose_drive: assert property (p_expose_drive) else $error("exposing not driven");

    property p_input_quiet;
        @(posedge pclk) disable iff (!presetn)
            !pin_direction_reg[3] && !pin_polarity_flip_reg[3] |=> !io_pin_out[3];
    endproperty
    a_input_quiet: assert property (p_input_quiet) else $error("input line driven");

    sequence s_setup;
        psel && !penable;
    endsequence
    property p_ready_timing;
        @(posedge pclk) disable iff (!presetn) s_setup |=> pready;
    endproperty
    a_ready_timing: assert property (p_ready_timing) else $error("pready late");

    property p_packed_read;
        @(posedge pclk) disable iff (!presetn)
            s_setup ##0 (!pwrite && paddr == cgl_pkg::OFF_PACKED) |=> prdata == {28'h0, $past(level)};
    endproperty
    a_packed_read: assert property (p_packed_read) else $error("packed levels wrong");

    // ************************************************************
    // assertion helpers
    // ************************************************************
    logic             wr_bit;
    logic [1:0]       wr_choice;
    logic [LINES-1:0] choice_mask;

    assign wr_bit      = req.wdata[0];
    assign wr_choice   = req.wdata[1:0];
    assign choice_mask = LINES'(1) << io_pin_choice_reg;

    sequence s_write_access;
        psel && penable && pwrite && pready;
    endsequence

    property p_choice_write;
        @(posedge pclk) disable iff (!presetn)
            s_write_access ##0 (paddr == cgl_pkg::OFF_CHOICE)
            |=> io_pin_choice_reg == $past(wr_choice);
    endproperty
    a_choice_write: assert property (p_choice_write) else $error("choice not stored");

    property p_dir_write;
        @(posedge pclk) disable iff (!presetn)
            s_write_access ##0 (paddr == cgl_pkg::OFF_DIRECTION)
            |=> pin_direction_reg[$past(io_pin_choice_reg)] == $past(wr_bit);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not stored");

    property p_others_kept;
        @(posedge pclk) disable iff (!presetn)
            s_write_access ##0 (paddr == cgl_pkg::OFF_DIRECTION)
            |=> ((pin_direction_reg ^ $past(pin_direction_reg)) & ~$past(choice_mask)) == '0;
    endproperty
    a_others_kept: assert property (p_others_kept) else $error("other line changed");

    property p_flip_write;
        @(posedge pclk) disable iff (!presetn)
            s_write_access ##0 (paddr == cgl_pkg::OFF_FLIP)
            |=> pin_polarity_flip_reg[$past(io_pin_choice_reg)] == $past(wr_bit);
    endproperty
    a_flip_write: assert property (p_flip_write) else $error("flip not stored");

    property p_aux_write;
        @(posedge pclk) disable iff (!presetn)
            s_write_access ##0 (paddr == cgl_pkg::OFF_AUX_RAIL)
            |=> aux_rail_on == $past(wr_bit);
    endproperty
    a_aux_write: assert property (p_aux_write) else $error("rail switch not stored");

    property p_off_drive;
        @(posedge pclk) disable iff (!presetn)
            pin_direction_reg[0] && !pin_polarity_flip_reg[0]
            && pin_drive_select_reg[0] == cgl_pkg::SRC_OFF |=> !io_pin_out[0];
    endproperty
    a_off_drive: assert property (p_off_drive) else $error("off source driven");

    property p_loop_high;
        @(posedge pclk) disable iff (!presetn)
            pin_direction_reg[1] && !pin_polarity_flip_reg[1] && sync2_reg[0]
            && pin_drive_select_reg[1] == cgl_pkg::SRC_LINE0 |=> io_pin_out[1];
    endproperty
    a_loop_high: assert property (p_loop_high) else $error("loopback high lost");

    property p_loop_low;
        @(posedge pclk) disable iff (!presetn)
            pin_direction_reg[1] && !pin_polarity_flip_reg[1] && !sync2_reg[0]
            && pin_drive_select_reg[1] == cgl_pkg::SRC_LINE0 |=> !io_pin_out[1];
    endproperty
    a_loop_low: assert property (p_loop_low) else $error("loopback low lost");

    property p_trig_drive;
        @(posedge pclk) disable iff (!presetn)
            pin_direction_reg[3] && !pin_polarity_flip_reg[3] && trigger_ready_flag
            && pin_drive_select_reg[3] == cgl_pkg::SRC_TRIG_READY |=> io_pin_out[3];
    endproperty
    a_trig_drive: assert property (p_trig_drive) else $error("trigger ready not driven");

    property p_trig_idle;
        @(posedge pclk) disable iff (!presetn)
            pin_direction_reg[3] && !pin_polarity_flip_reg[3] && !trigger_ready_flag
            && pin_drive_select_reg[3] == cgl_pkg::SRC_TRIG_READY |=> !io_pin_out[3];
    endproperty
    a_trig_idle: assert property (p_trig_idle) else $error("trigger wait not low");

    property p_flip_inverts;
        @(posedge pclk) disable iff (!presetn)
            pin_direction_reg[3] && pin_polarity_flip_reg[3] && !trigger_ready_flag
            && pin_drive_select_reg[3] == cgl_pkg::SRC_TRIG_READY |=> io_pin_out[3];
    endproperty
    a_flip_inverts: assert property (p_flip_inverts) else $error("output not inverted");

    property p_serial_tx;
        @(posedge pclk) disable iff (!presetn)
            pin_direction_reg[0] && !pin_polarity_flip_reg[0]
            && pin_drive_select_reg[0] == cgl_pkg::SRC_SERIAL_TX
            |=> io_pin_out[0] == $past(serial_tx_data);
    endproperty
    a_serial_tx: assert property (p_serial_tx) else $error("serial transmit not driven");

    property p_rx_high;
        @(posedge pclk) disable iff (!presetn)
            sync2_reg[1] && !pin_polarity_flip_reg[1] |=> serial_rx_data;
    endproperty
    a_rx_high: assert property (p_rx_high) else $error("serial receive not high");

    property p_rx_flipped;
        @(posedge pclk) disable iff (!presetn)
            !sync2_reg[1] && pin_polarity_flip_reg[1] |=> serial_rx_data;
    endproperty
    a_rx_flipped: assert property (p_rx_flipped) else $error("receive not inverted");

    property p_sync_two_stage;
        @(posedge pclk) disable iff (!presetn) sync2_reg == $past(sync1_reg);
    endproperty
    a_sync_two_stage: assert property (p_sync_two_stage) else $error("sync skipped");

    property p_readback_high;
        @(posedge pclk) disable iff (!presetn)
            s_setup ##0 (!pwrite && paddr == cgl_pkg::OFF_READBACK)
            ##0 level[io_pin_choice_reg] |=> prdata == 32'h0000_0001;
    endproperty
    a_readback_high: assert property (p_readback_high) else $error("status not one");

    property p_readback_low;
        @(posedge pclk) disable iff (!presetn)
            s_setup ##0 (!pwrite && paddr == cgl_pkg::OFF_READBACK)
            ##0 !level[io_pin_choice_reg] |=> prdata == 32'h0000_0000;
    endproperty
    a_readback_low: assert property (p_readback_low) else $error("status not zero");

    property p_reset_settings;
        @(posedge pclk) $rose(presetn) |-> pin_direction_reg == '0
            && pin_polarity_flip_reg == '0 && io_pin_out == '0 && serial_rx_data;
    endproperty
    a_reset_settings: assert property (p_reset_settings) else $error("settings not idle");

endmodule // cgl_gpio_ctrl

/* cgl_pin_world.sv */
// pin-side model: outside circuits wired to the four gpio lines
`timescale 1ns/10ps
module cgl_pin_world (
    // device side
    input  wire logic [3:0] io_pin_out,
    input  wire logic [3:0] io_pin_oe,
    // levels the outside circuits put on undriven lines
    input  wire logic [3:0] ext_level,
    // resolved wire levels
    output logic      [3:0] io_pin_in
);
    // a driven line shows the device value, an undriven one the outside level
    assign io_pin_in = (io_pin_oe & io_pin_out) | (~io_pin_oe & ext_level);
endmodule // cgl_pin_world

/* testbench.sv */
// self-checking bench for the camera gpio line control
`timescale 1ns/10ps
module testbench;
    // ************************************************************
    // signals
    // ************************************************************
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        sensor_exposing_flag, trigger_ready_flag, serial_tx_data;
    logic        serial_rx_data, aux_rail_on;
    logic [3:0]  io_pin_in, io_pin_out, io_pin_oe, ext_level;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;
    typedef struct packed {
        logic [1:0] line;
        logic       dir;
        logic       flip;
        logic [2:0] src;
        logic [3:0] ext;
        logic [2:0] flags;
        logic       out;
    } cgl_row_t;
    // flags are {serial tx, trigger ready, exposing}
    cgl_row_t rows [8] = '{
        '{2'h2, 1'h0, 1'h0, 3'h5, 4'h4, 3'h1, 1'h0},
        '{2'h2, 1'h1, 1'h0, 3'h5, 4'h0, 3'h1, 1'h1},
        '{2'h2, 1'h1, 1'h0, 3'h5, 4'h0, 3'h0, 1'h0},
        '{2'h3, 1'h1, 1'h0, 3'h6, 4'h0, 3'h2, 1'h1},
        '{2'h3, 1'h1, 1'h1, 3'h6, 4'h0, 3'h0, 1'h1},
        '{2'h1, 1'h1, 1'h0, 3'h1, 4'h1, 3'h0, 1'h1},
        '{2'h0, 1'h1, 1'h0, 3'h0, 4'h0, 3'h4, 1'h0},
        '{2'h0, 1'h1, 1'h0, 3'h7, 4'h0, 3'h4, 1'h1}};
    // ************************************************************
    // design, pins and clock
    // ************************************************************
    cgl_gpio_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sensor_exposing_flag(sensor_exposing_flag),
        .trigger_ready_flag(trigger_ready_flag), .serial_tx_data(serial_tx_data),
        .serial_rx_data(serial_rx_data), .io_pin_in(io_pin_in), .io_pin_out(io_pin_out),
        .io_pin_oe(io_pin_oe), .aux_rail_on(aux_rail_on));
    cgl_pin_world pins (.io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
        .ext_level(ext_level), .io_pin_in(io_pin_in));
    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            report_and_stop();
        end
    end
    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        presetn = 1'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {serial_tx_data, trigger_ready_flag, sensor_exposing_flag} = 3'h0;
        ext_level = 4'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        foreach (rows[i]) begin
            {serial_tx_data, trigger_ready_flag, sensor_exposing_flag} <= rows[i].flags;
            ext_level <= rows[i].ext;
            apb(1'h1, cgl_pkg::OFF_CHOICE, {30'h0, rows[i].line});
            apb(1'h1, cgl_pkg::OFF_DIRECTION, {31'h0, rows[i].dir});
            apb(1'h1, cgl_pkg::OFF_FLIP, {31'h0, rows[i].flip});
            apb(1'h1, cgl_pkg::OFF_DRIVE_SEL, {29'h0, rows[i].src});
            repeat (4) @(posedge pclk);
            check("pin out", {31'h0, io_pin_out[rows[i].line]},
                  {31'h0, rows[i].out});
            check("pin oe", {31'h0, io_pin_oe[rows[i].line]}, {31'h0, rows[i].dir});
            apb(1'h0, cgl_pkg::OFF_READBACK, 32'h0);
            check("readback", rd, {31'h0, rows[i].dir ? rows[i].out
                  : rows[i].ext[rows[i].line] ^ rows[i].flip});
            $display("row %0d done", i);
        end
        apb(1'h1, cgl_pkg::OFF_CHOICE, 32'h0000_0002);
        apb(1'h0, cgl_pkg::OFF_DRIVE_SEL, 32'h0);
        check("line2 source", rd, {29'h0, cgl_pkg::SRC_EXPOSING});
        apb(1'h0, cgl_pkg::OFF_CHOICE, 32'h0);
        check("choice", rd, 32'h0000_0002);
        apb(1'h1, cgl_pkg::OFF_AUX_RAIL, 32'h0000_0001);
        @(posedge pclk);
        check("aux rail", {31'h0, aux_rail_on}, 32'h0000_0001);
        apb(1'h0, cgl_pkg::OFF_AUX_RAIL, 32'h0);
        check("aux readback", rd, 32'h0000_0001);
        apb(1'h0, 12'h01C, 32'h0);
        check("unmapped data", rd, cgl_pkg::BAD_ADDR_DATA);
        check("unmapped err", {31'h0, err}, 32'h0000_0001);
        apb(1'h1, cgl_pkg::OFF_PACKED, 32'hFFFF_FFFF);
        check("read-only err", {31'h0, err}, 32'h0);
        $display("register tests done");
        presetn <= 1'h0;
        ext_level <= 4'hA;
        @(posedge pclk);
        check("reset oe", {28'h0, io_pin_oe}, 32'h0);
        check("reset aux", {31'h0, aux_rail_on}, 32'h0);
        presetn <= 1'h1;
        apb(1'h0, cgl_pkg::OFF_DIRECTION, 32'h0);
        check("reset direction", rd, 32'h0);
        apb(1'h0, cgl_pkg::OFF_PACKED, 32'h0);
        check("packed levels", rd, 32'h0000_000A);
        check("serial rx high", {31'h0, serial_rx_data}, 32'h0000_0001);
        ext_level <= 4'h5;
        repeat (2) @(posedge pclk);
        apb(1'h0, cgl_pkg::OFF_PACKED, 32'h0);
        check("packed levels", rd, 32'h0000_0005);
        check("serial rx low", {31'h0, serial_rx_data}, 32'h0);
        apb(1'h1, cgl_pkg::OFF_CHOICE, 32'h0000_0001);
        apb(1'h1, cgl_pkg::OFF_FLIP, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        check("flipped rx", {31'h0, serial_rx_data}, 32'h0000_0001);
        apb(1'h0, cgl_pkg::OFF_READBACK, 32'h0);
        check("flipped input", rd, 32'h0000_0001);
        $display("reset and pin tests done");
        report_and_stop();
    end
endmodule // testbench
